/* File: rtl/adc_cfg_pkg.sv */
// Constants shared by both ends of the configuration register link
// Function
// - Scan gap code selects zero or 8..512 periods
// - Host writes zero to scan bit 20
// - Scan bits 19..16 ignore writes, read zero
// - Low sixteen scan bits select conversions, reset zero
// - Timed mode waits interval register between cycles
// - Offset trim is two's complement, resets zero
// - Gain trim unsigned, resets to unity 800000
// - Word at 0xb resets 0x900000, host keeps it
// - Byte at 0xc resets 0x50, host keeps it
// - Key 0xa5 unlocks writes, checksum reads zero
// - Other key blocks writes except key register
// - Locked checksum recomputed only while master clock runs
// - Read-only checksum at 0xf is CRC-16
// - Word at 0xe holds variant value only; code lets an unlocked host overwrite it
// - Act only when command address bits match
package adc_cfg_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] A_SCAN = 4'h7;
  localparam logic [3:0] A_TIMER = 4'h8;
  localparam logic [3:0] A_OFFSET = 4'h9;
  localparam logic [3:0] A_GAIN = 4'ha;
  localparam logic [3:0] A_RSV_B = 4'hb;
  localparam logic [3:0] A_RSV_C = 4'hc;
  localparam logic [3:0] A_KEY = 4'hd;
  localparam logic [3:0] A_RSV_E = 4'he;
  localparam logic [3:0] A_CRC = 4'hf;

  localparam logic [23:0] RST_SCAN = 24'h000000;
  localparam logic [23:0] RST_TIMER = 24'h000000;
  localparam logic [23:0] RST_OFFSET = 24'h000000;
  localparam logic [23:0] RST_GAIN = 24'h800000;
  localparam logic [23:0] RST_RSV_B = 24'h900000;
  localparam logic [7:0] RST_RSV_C = 8'h50;
  localparam logic [7:0] KEY_OPEN = 8'ha5;
  // Variant word default: arbitrary value
  localparam logic [15:0] RST_RSV_E_DEF = 16'h0001;

  // Scan register fields
  localparam int GAP_MSB = 23;
  localparam int GAP_LSB = 21;
  localparam int SCAN_RSV_BIT = 20;
  localparam logic [23:0] SCAN_WR_MASK = 24'hf0ffff;
  localparam logic [9:0] GAP_UNIT = 10'h008;

  // ************************************************************
  // Command byte
  // ************************************************************
  localparam logic [1:0] DEV_ADDR_DEF = 2'b01;
  localparam logic [1:0] CMD_WRITE = 2'b10;
  localparam logic [1:0] CMD_READ = 2'b11;
  localparam logic [1:0] MODE_TIMED = 2'b11;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] DATA_MAX = 6'h18;

  // Checksum engine
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam int CFG_BITS = 152;

  // Data bits carried for each register address
  function automatic logic [5:0] reg_width(input logic [3:0] a);
    if (a >= A_SCAN && a <= A_RSV_B) begin
      return 6'h18;
    end else if (a == A_RSV_C || a == A_KEY) begin
      return 6'h08;
    end else if (a == A_RSV_E || a == A_CRC) begin
      return 6'h10;
    end
    return 6'h00;
  endfunction

  // Gap in master periods for a scan gap code
  function automatic logic [9:0] gap_len(input logic [2:0] code);
    if (code == 3'h0) begin
      return 10'h000;
    end
    return GAP_UNIT << (code - 3'h1);
  endfunction

endpackage

/* File: rtl/adc_cfg_link_if.sv */
// Serial command link between host and converter register map
`timescale 1ns/1ns
interface adc_cfg_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // Undriven data-out line floats high through the pull-up
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport device (input cs_n, input sck, input sdi, output sdo, output sdo_oe);
  modport host (output cs_n, output sck, output sdi, input sdo_line);
endinterface

/* File: rtl/adc_cfg_regs.sv */
// Converter end: upper register map, write lock, checksum, scan timing
`timescale 1ns/1ns
module adc_cfg_regs
  import adc_cfg_pkg::*;
#(
  parameter logic [1:0] DEV_ADDR = DEV_ADDR_DEF,
  parameter logic [15:0] RSV_E_RESET = RST_RSV_E_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Serial link
  adc_cfg_link_if.device LINK,
  // Conversion engine
  input wire logic MCLK_RUN,
  input wire logic MCLK_TICK,
  input wire logic [1:0] CONVERSION_KIND_FIELD,
  input wire logic CONV_DONE,
  input wire logic CYCLE_DONE,
  output logic CONV_START,
  output logic [15:0] SCAN_SELECT,
  output logic [23:0] OFFSET_TRIM,
  output logic [23:0] GAIN_TRIM,
  // Lock state
  output logic LOCKED,
  output logic [15:0] CHECKSUM
);

  // ************************************************************
  // Link edge detection
  // ************************************************************
  logic sck_q;
  wire sck_rise = LINK.sck & ~sck_q;
  wire sck_fall = ~LINK.sck & sck_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= LINK.sck;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [23:0] scan_q, timer_q, offset_q, gain_q, rsv_b_q;
  logic [7:0] rsv_c_q, key_q;
  logic [15:0] rsv_e_q, crc_q;
  logic [15:0] rsv_e_init_q;

  // ************************************************************
  // Frame decoding
  // ************************************************************
  logic [5:0] bit_cnt_q;
  logic [23:0] rx_q;
  logic [7:0] cmd_q;
  logic [23:0] tx_q;
  logic sdo_q;

  wire [7:0] cmd_now = {rx_q[6:0], LINK.sdi};
  wire [3:0] cmd_reg = cmd_q[5:2];
  wire [5:0] width = reg_width(cmd_reg);
  wire addressed = cmd_q[7:6] == DEV_ADDR;
  wire in_frame = ~LINK.cs_n;
  wire cmd_done = in_frame & sck_rise & (bit_cnt_q == CMD_BITS - 6'h01);
  wire is_read = addressed & (cmd_q[1:0] == CMD_READ) & (width != 6'h00);
  wire is_write = addressed & (cmd_q[1:0] == CMD_WRITE) & (width != 6'h00);
  wire last_bit = in_frame & sck_rise & (bit_cnt_q == CMD_BITS + width - 6'h01);
  wire [23:0] wr_data = {rx_q[22:0], LINK.sdi};
  wire unlocked = key_q == KEY_OPEN;
  // Key register stays writable so the host can always unlock
  wire wr_allowed = (cmd_reg == A_KEY) | (unlocked & cmd_reg != A_CRC);
  wire commit = last_bit & is_write & wr_allowed & (bit_cnt_q >= CMD_BITS);

  // Read data selection, left aligned for MSB first shifting
  logic [23:0] rd_word;
  wire cmd_now_read = (cmd_now[7:6] == DEV_ADDR) & (cmd_now[1:0] == CMD_READ);
  wire [3:0] cmd_now_reg = cmd_now[5:2];
  wire [5:0] rd_width = reg_width(cmd_now_reg);
  always_comb begin
    case (cmd_now_reg)
      A_SCAN: rd_word = scan_q & SCAN_WR_MASK;
      A_TIMER: rd_word = timer_q;
      A_OFFSET: rd_word = offset_q;
      A_GAIN: rd_word = gain_q;
      A_RSV_B: rd_word = rsv_b_q;
      A_RSV_C: rd_word = {16'h0000, rsv_c_q};
      A_KEY: rd_word = {16'h0000, key_q};
      A_RSV_E: rd_word = {8'h00, rsv_e_q};
      A_CRC: rd_word = {8'h00, crc_q};
      default: rd_word = 24'h000000;
    endcase
  end
  wire [23:0] rd_aligned = rd_word << (DATA_MAX - rd_width);

  // Bit counter, command byte and receive shifter; counter and command byte cleared between frames
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_cnt_q <= 6'h00;
      rx_q <= 24'h000000;
      cmd_q <= 8'h00;
    end else if (!in_frame) begin
      bit_cnt_q <= 6'h00;
      cmd_q <= 8'h00;
    end else if (sck_rise) begin
      rx_q <= wr_data;
      if (bit_cnt_q != 6'h3f) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
      if (cmd_done) begin
        cmd_q <= cmd_now;
      end
    end
  end

  // Transmit shifter: loaded at command end, advanced on falling edges
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_q <= 24'h000000;
      sdo_q <= 1'b0;
    end else if (cmd_done) begin
      tx_q <= cmd_now_read ? rd_aligned : 24'h000000;
    end else if (in_frame & sck_fall & is_read) begin
      sdo_q <= tx_q[23];
      tx_q <= {tx_q[22:0], 1'b0};
    end
  end

  // Only a matching read drives the data line
  assign LINK.sdo = sdo_q;
  assign LINK.sdo_oe = in_frame & is_read & (bit_cnt_q >= CMD_BITS);

  // ************************************************************
  // Register writes
  // ************************************************************
  // Variant word reset value captured after reset release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scan_q <= RST_SCAN;
      timer_q <= RST_TIMER;
      offset_q <= RST_OFFSET;
      gain_q <= RST_GAIN;
      rsv_b_q <= RST_RSV_B;
      rsv_c_q <= RST_RSV_C;
      key_q <= KEY_OPEN;
      rsv_e_q <= 16'h0000;
      rsv_e_init_q <= 16'h0000;
    end else if (rsv_e_init_q == 16'h0000) begin
      rsv_e_q <= RSV_E_RESET;
      rsv_e_init_q <= 16'hffff;
    end else if (commit) begin
      case (cmd_reg)
        A_SCAN: scan_q <= wr_data & SCAN_WR_MASK;
        A_TIMER: timer_q <= wr_data;
        A_OFFSET: offset_q <= wr_data;
        A_GAIN: gain_q <= wr_data;
        A_RSV_B: rsv_b_q <= wr_data;
        A_RSV_C: rsv_c_q <= wr_data[7:0];
        A_KEY: key_q <= wr_data[7:0];
        A_RSV_E: rsv_e_q <= wr_data[15:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Configuration checksum
  // ************************************************************
  // Bit-serial pass over the image; result published when a pass ends
  wire [CFG_BITS-1:0] cfg_image = {scan_q & SCAN_WR_MASK, timer_q, offset_q, gain_q, rsv_b_q,
                                   rsv_c_q, key_q, rsv_e_q};
  logic [7:0] crc_idx_q;
  logic [15:0] crc_acc_q;
  wire crc_in = cfg_image[CFG_BITS - 1 - crc_idx_q];
  wire crc_fb = crc_acc_q[15] ^ crc_in;
  wire [15:0] crc_next = {crc_acc_q[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : 16'h0000);
  wire pass_end = crc_idx_q == 8'(CFG_BITS - 1);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      crc_idx_q <= 8'h00;
      crc_acc_q <= 16'h0000;
      crc_q <= 16'h0000;
    end else if (unlocked) begin
      crc_idx_q <= 8'h00;
      crc_acc_q <= 16'h0000;
      crc_q <= 16'h0000;
    end else if (MCLK_RUN) begin
      crc_idx_q <= pass_end ? 8'h00 : crc_idx_q + 8'h01;
      crc_acc_q <= pass_end ? 16'h0000 : crc_next;
      if (pass_end) begin
        crc_q <= crc_next;
      end
    end
  end

  // ************************************************************
  // Scan timing
  // ************************************************************
  typedef enum logic {SQ_IDLE, SQ_WAIT} seq_e;
  seq_e seq_q;
  logic [23:0] wait_q;
  logic start_q;

  // Gap after a conversion, interval after a cycle in timed mode
  wire [23:0] gap_load = {14'h0000, gap_len(scan_q[GAP_MSB:GAP_LSB])};
  wire [23:0] cyc_load = (CONVERSION_KIND_FIELD == MODE_TIMED) ? timer_q : 24'h000000;
  wire [23:0] wait_load = CYCLE_DONE ? cyc_load : gap_load;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seq_q <= SQ_IDLE;
      wait_q <= 24'h000000;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (seq_q)
        SQ_IDLE: begin
          if (CONV_DONE && wait_load == 24'h000000) begin
            start_q <= 1'b1;
          end else if (CONV_DONE) begin
            wait_q <= wait_load;
            seq_q <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (MCLK_TICK && wait_q == 24'h000001) begin
            start_q <= 1'b1;
            seq_q <= SQ_IDLE;
          end else if (MCLK_TICK) begin
            wait_q <= wait_q - 24'h000001;
          end
        end
        default: seq_q <= SQ_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Outputs to the conversion engine and lock state
  // ************************************************************
  assign CONV_START = start_q;
  assign SCAN_SELECT = scan_q[15:0];
  assign OFFSET_TRIM = offset_q;
  assign GAIN_TRIM = gain_q;
  assign LOCKED = ~unlocked;
  assign CHECKSUM = crc_q;

endmodule // adc_cfg_regs

/* File: rtl/adc_cfg_host.sv */
// Host end: runs one register read or write per serial frame
`timescale 1ns/1ns
module adc_cfg_host
  import adc_cfg_pkg::*;
#(
  parameter int HALF_PERIOD = 2
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Serial link
  adc_cfg_link_if.host LINK,
  // Request
  input wire logic START,
  input wire logic WRITE,
  input wire logic [1:0] DEV_ADDR,
  input wire logic [3:0] REG_ADDR,
  input wire logic [23:0] WDATA,
  // Answer
  output logic BUSY,
  output logic DONE,
  output logic [23:0] RDATA
);

  // The far end samples the clock with its own clock, so two cycles per half
  if (HALF_PERIOD < 2 || HALF_PERIOD > 255) begin : g_half_check
    $error("HALF_PERIOD out of range");
  end

  typedef enum logic {H_IDLE, H_RUN} host_e;
  host_e st_q;
  logic [7:0] div_q;
  logic sck_q, cs_n_q, done_q;
  logic [31:0] tx_q;
  logic [23:0] rx_q, rdata_q;
  logic [5:0] cnt_q, total_q;

  // ************************************************************
  // Frame sequencing
  // ************************************************************
  wire [5:0] w = reg_width(REG_ADDR);
  wire [1:0] kind = WRITE ? CMD_WRITE : CMD_READ;
  wire half_end = div_q == 8'(HALF_PERIOD - 1);
  wire last = cnt_q == total_q;

  // Data always goes out MSB first, left aligned behind the command
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= H_IDLE;
      div_q <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      done_q <= 1'b0;
      tx_q <= 32'h00000000;
      rx_q <= 24'h000000;
      rdata_q <= 24'h000000;
      cnt_q <= 6'h00;
      total_q <= 6'h00;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (START) begin
            // the caller supplies the mandated values
            tx_q <= {DEV_ADDR, REG_ADDR, kind, WDATA << (DATA_MAX - w)};
            total_q <= CMD_BITS + w;
            cnt_q <= 6'h00;
            div_q <= 8'h00;
            cs_n_q <= 1'b0;
            st_q <= H_RUN;
          end
        end
        H_RUN: begin
          div_q <= half_end ? 8'h00 : div_q + 8'h01;
          if (half_end && !sck_q && last) begin
            cs_n_q <= 1'b1;
            rdata_q <= rx_q;
            done_q <= 1'b1;
            st_q <= H_IDLE;
          end else if (half_end && !sck_q) begin
            sck_q <= 1'b1;
            // Command-phase bits dropped so short reads come back zero padded
            rx_q <= (cnt_q < CMD_BITS) ? 24'h000000 : {rx_q[22:0], LINK.sdo_line};
            cnt_q <= cnt_q + 6'h01;
          end else if (half_end) begin
            sck_q <= 1'b0;
            tx_q <= {tx_q[30:0], 1'b0};
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign LINK.cs_n = cs_n_q;
  assign LINK.sck = sck_q;
  assign LINK.sdi = tx_q[31];
  assign BUSY = st_q == H_RUN;
  assign DONE = done_q;
  assign RDATA = rdata_q;

endmodule // adc_cfg_host

/* File: verification/adc_cfg_props.sv */
// Concurrent checks on the register link and the converter end
`timescale 1ns/1ns
module adc_cfg_props
  import adc_cfg_pkg::*;
#(
  parameter logic [1:0] DEV_ADDR = DEV_ADDR_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_oe,
  // Converter end
  input wire logic MCLK_RUN,
  input wire logic [1:0] CONVERSION_KIND_FIELD,
  input wire logic CONV_DONE,
  input wire logic CYCLE_DONE,
  input wire logic CONV_START,
  input wire logic LOCKED,
  input wire logic [15:0] CHECKSUM
);
  // ************
  // Frame tracking
  // ************
  logic sck_q;
  logic wait_q;
  logic [5:0] cnt_q;
  logic [7:0] cmd_q;
  wire rise = sck & ~sck_q;
  wire [3:0] ra = cmd_q[5:2];
  // Data bits expected after the command, by address
  wire [5:0] want = (ra >= 4'h7 && ra <= 4'hb) ? 6'h18 : (ra == 4'hc || ra == 4'hd) ? 6'h08 :
    (ra >= 4'he) ? 6'h10 : 6'h00;

  // Same sampling as the device, so counts line up with its view
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sck_q <= 1'b0;
      cnt_q <= 6'h00;
      cmd_q <= 8'h00;
      wait_q <= 1'b0;
    end else begin
      sck_q <= sck;
      cnt_q <= cs_n ? 6'h00 : cnt_q + {5'h00, rise};
      cmd_q <= (rise && !cs_n && cnt_q < 6'h08) ? {cmd_q[6:0], sdi} : cmd_q;
      wait_q <= (wait_q & ~CONV_START) | CONV_DONE;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  crc_clear_a: assert property (!LOCKED |=> CHECKSUM == 16'h0000)
    else $error("checksum not zero while unlocked");
  crc_hold_a: assert property (LOCKED && !MCLK_RUN |=> $stable(CHECKSUM))
    else $error("checksum moved with master clock stopped");
  addr_guard_a: assert property (cnt_q >= 6'h08 && cmd_q[7:6] != DEV_ADDR |-> !sdo_oe)
    else $error("device answered a foreign address");
  oe_idle_a: assert property (cs_n |-> !sdo_oe)
    else $error("data out driven outside a frame");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("link clock not idle low");
  sdi_stable_a: assert property (sck |-> $stable(sdi))
    else $error("data in changed while clock high");
  frame_len_a: assert property ($rose(cs_n) |-> cnt_q == 6'h08 + want)
    else $error("frame bit count wrong for address");
  start_cause_a: assert property (CONV_START |-> wait_q)
    else $error("conversion start without a finished conversion");
  cycle_restart_a: assert property (CONV_DONE && CYCLE_DONE && CONVERSION_KIND_FIELD != MODE_TIMED && !wait_q
    |=> CONV_START)
    else $error("untimed cycle did not restart at once");

  cover property ($rose(LOCKED));
  cover property (CONV_START && !CYCLE_DONE);
  cover property (sdo_oe && cnt_q == 6'h10);
endmodule // adc_cfg_props

/* File: verification/testbench.sv */
// Self-checking bench joining host end and converter end
`timescale 1ns/1ns
module testbench
  import adc_cfg_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic wr = 1'b0;
  logic [1:0] dev = 2'b00;
  logic [3:0] ra = 4'h0;
  logic [23:0] wdata = 24'h000000;
  logic run = 1'b1;
  logic tick = 1'b0;
  logic tick_en = 1'b0;
  logic [1:0] mode = 2'b00;
  logic cdone = 1'b0;
  logic cyc = 1'b0;
  logic busy, done, cstart, locked;
  logic [23:0] rdata, offs, gain, v;
  logic [15:0] scan_sel, crc;
  logic [9:0] ticks = 10'h000;
  logic [24:0] rd_q[$];
  logic [9:0] gap_q[$];
  logic [23:0] sv [3];
  logic [23:0] rv [9] = '{24'h0, 24'h0, 24'h0, 24'h800000, 24'h900000, 24'h50, 24'ha5, {8'h0, RST_RSV_E_DEF}, 24'h0};
  int n_mismatch = 0;
  int check_count = 0;

  always #25 clk = ~clk;

  adc_cfg_link_if link ();
  adc_cfg_regs adc_cfg_regs_inst (.CLK(clk), .RST(rst), .LINK(link.device), .MCLK_RUN(run), .MCLK_TICK(tick),
    .CONVERSION_KIND_FIELD(mode), .CONV_DONE(cdone), .CYCLE_DONE(cyc), .CONV_START(cstart), .SCAN_SELECT(scan_sel),
    .OFFSET_TRIM(offs), .GAIN_TRIM(gain), .LOCKED(locked), .CHECKSUM(crc));
  adc_cfg_host adc_cfg_host_inst (.CLK(clk), .RST(rst), .LINK(link.host), .START(start), .WRITE(wr),
    .DEV_ADDR(dev), .REG_ADDR(ra), .WDATA(wdata), .BUSY(busy), .DONE(done), .RDATA(rdata));
  adc_cfg_props #(.DEV_ADDR(DEV_ADDR_DEF)) adc_cfg_props_inst (.CLK(clk), .RST(rst), .cs_n(link.cs_n),
    .sck(link.sck), .sdi(link.sdi), .sdo_oe(link.sdo_oe), .MCLK_RUN(run), .CONVERSION_KIND_FIELD(mode),
    .CONV_DONE(cdone), .CYCLE_DONE(cyc), .CONV_START(cstart), .LOCKED(locked), .CHECKSUM(crc));

  // ************
  // Shared tasks
  // ************
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One frame; the note carries a compare flag above the expected read value
  task automatic xfer(input logic w, input logic [1:0] d, input logic [3:0] a, input logic [23:0] x,
    input logic [24:0] e);
    @(posedge clk);
    start <= 1'b1;
    wr <= w;
    dev <= d;
    ra <= a;
    wdata <= x;
    rd_q.push_back(e);
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [23:0] e);
    xfer(1'b0, DEV_ADDR_DEF, a, 24'h000000, {1'b1, e});
  endtask

  task automatic wreg(input logic [3:0] a, input logic [23:0] x);
    xfer(1'b1, DEV_ADDR_DEF, a, x, 25'h0);
  endtask

  // Finished conversion, then random master ticks until the next start
  task automatic seq(input logic c, input logic [1:0] m, input logic [9:0] e);
    gap_q.push_back(e);
    @(posedge clk);
    cyc <= c;
    mode <= m;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
    tick_en <= 1'b1;
    for (int i = 0; i < 1200 && gap_q.size() > 0; i++) @(posedge clk);
    tick_en <= 1'b0;
  endtask

  function automatic logic [15:0] crc16(input logic [151:0] m);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 151; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Ticks held low at the load edge so the count start is unambiguous
  always @(posedge clk) tick <= tick_en & 1'($urandom_range(1, 0));

  // Watcher: oldest note against each answer and each conversion start
  always @(posedge clk) begin
    if (done === 1'b1 && rd_q.size() > 0) begin
      if (rd_q[0][24]) check(rdata, rd_q[0][23:0]);
      void'(rd_q.pop_front());
    end
    if (cstart === 1'b1 && gap_q.size() > 0) check({14'h0, ticks}, {14'h0, gap_q.pop_front()});
    ticks <= (rst || cdone) ? 10'h000 : ticks + {9'h0, tick};
  end

  // ************
  // Scenarios
  // ************
  initial begin
    void'($urandom(91053));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 9; i++) rd(4'h7 + 4'(i), rv[i]);
    xfer(1'b0, DEV_ADDR_DEF, 4'h3, 24'h0, 25'h0);
    v = 24'($urandom()) & 24'hefffff;
    wreg(A_SCAN, v);
    rd(A_SCAN, v & 24'hf0ffff);
    check({8'h0, scan_sel}, {8'h0, v[15:0]});
    for (int i = 0; i < 3; i++) begin
      sv[i] = 24'($urandom());
      wreg(A_TIMER + 4'(i), sv[i]);
      rd(A_TIMER + 4'(i), sv[i]);
    end
    check(offs, sv[1]);
    check(gain, sv[2]);
    xfer(1'b1, ~DEV_ADDR_DEF, A_GAIN, ~sv[2], 25'h0);
    rd(A_GAIN, sv[2]);
    for (int c = 0; c < 8; c++) begin
      wreg(A_SCAN, {3'(c), 21'h0});
      seq(1'b0, 2'b00, (c == 0) ? 10'h000 : 10'h008 << (c - 1));
    end
    sv[0] = 24'h000007;
    wreg(A_TIMER, sv[0]);
    seq(1'b1, MODE_TIMED, 10'h007);
    seq(1'b1, 2'b01, 10'h000);
    // Master clock stopped across the lock, so the checksum must not advance
    run <= 1'b0;
    wreg(A_KEY, 24'h00003c);
    check({23'h0, locked}, 24'h1);
    wreg(A_GAIN, ~sv[2]);
    rd(A_GAIN, sv[2]);
    check(gain, sv[2]);
    repeat (200) @(posedge clk);
    check({8'h0, crc}, 24'h000000);
    run <= 1'b1;
    repeat (400) @(posedge clk);
    rd(A_CRC, {8'h0, crc16({24'he00000, sv[0], sv[1], sv[2], 24'h900000, 8'h50, 8'h3c, RST_RSV_E_DEF})});
    wreg(A_KEY, 24'h0000a5);
    rd(A_CRC, 24'h000000);
    wreg(A_RSV_C, 24'h000050);
    rd(A_RSV_C, 24'h000050);
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("unexpected at %0t: timeout", $time);
    summarize();
  end
endmodule // testbench
